// ===== minimum_compare_move_unit.sv
/*
 Execution datapath for the minimum and absolute move instructions, with the
 accumulator, product register, flags and repeat counter held here.
 Assumes the decoder presents one operand on OPND_IN in every cycle that
 OPND_TAKE_OUT is high, all on CLK_IN.
*/
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "minmove_params.svh"
module minimum_compare_move_unit #(
	parameter int RPT_W = 16
) (
	input  wire logic              CLK_IN,           // Core clock.
	input  wire logic              SYS_RST_IN,       // Async reset, active high.
	input  wire logic [7:0]        REG_ADDR_IN,      // Register byte address.
	input  wire logic [31:0]       REG_WDATA_IN,     // Register write data.
	input  wire logic              REG_WR_IN,        // Write strobe.
	input  wire logic              REG_RD_IN,        // Read strobe.
	output logic      [31:0]       REG_RDATA_OUT,    // Read data, one cycle later.
	input  wire logic              CMD_VALID_IN,     // Instruction offered.
	input  wire minmove_pkg::opcode_e CMD_OP_IN,     // Instruction kind.
	input  wire logic              CMD_HIGH_HALF_IN, // Select upper accumulator half.
	input  wire logic [15:0]       CMD_DEST_IN,      // Absolute move destination.
	output logic                   CMD_READY_OUT,    // Unit idle, takes instruction.
	input  wire logic [31:0]       OPND_IN,          // Memory operand.
	output logic                   OPND_TAKE_OUT,    // Operand consumed this cycle.
	output logic                   MEM_WR_OUT,       // Data write strobe.
	output logic      [31:0]       MEM_ADDR_OUT,     // Data write address.
	output logic      [15:0]       MEM_DATA_OUT      // Data write value.
);
	import minmove_pkg::*;

	state_e            state;
	state_e            next_state;
	opcode_e           op;
	opcode_e           next_op;
	logic              high;
	logic              next_high;
	logic [31:0]       acc;
	logic [31:0]       next_acc;
	logic [31:0]       prod;
	logic [31:0]       next_prod;
	logic              n;
	logic              next_n;
	logic              z;
	logic              next_z;
	logic              c;
	logic              next_c;
	logic              v;
	logic              next_v;
	logic [RPT_W-1:0]  repeat_instruction;
	logic [RPT_W-1:0]  next_rpt;
	logic [RPT_W-1:0]  left;
	logic [RPT_W-1:0]  next_left;
	logic [15:0]       dest;
	logic [15:0]       next_dest;
	logic              next_mem_wr;
	logic [31:0]       next_mem_addr;
	logic [15:0]       next_mem_data;
	logic [31:0]       next_rdata;
	logic [15:0]       half;
	logic              h_lt;
	logic              h_eq;
	logic              h_gt;
	logic [32:0]       ldiff;
	logic              l_lt;
	logic              l_eq;
	logic              l_gt;
	logic              l_borrow;
	logic              l_ovf;
	logic              p_gt;
	logic              exe;

	assign exe           = (state == st_exec);
	assign CMD_READY_OUT = (state == st_idle);
	assign OPND_TAKE_OUT = exe;
	assign half          = high ? acc[31:16] : acc[15:0];
	assign h_lt          = $signed(half) < $signed(OPND_IN[15:0]);
	assign h_eq          = half == OPND_IN[15:0];
	assign h_gt          = !h_lt && !h_eq;
	// A 33-bit signed difference keeps the sign exact where 32 bits would wrap.
	assign ldiff         = {acc[31], acc} - {OPND_IN[31], OPND_IN};
	assign l_lt          = ldiff[32];
	assign l_eq          = acc == OPND_IN;
	assign l_gt          = !l_lt && !l_eq;
	assign l_borrow      = acc < OPND_IN;
	assign l_ovf         = (acc[31] != OPND_IN[31]) && (ldiff[31] != acc[31]);
	assign p_gt          = prod > OPND_IN;

	always_comb begin
		next_state    = state;
		next_op       = op;
		next_high     = high;
		next_acc      = acc;
		next_prod     = prod;
		next_n        = n;
		next_z        = z;
		next_c        = c;
		next_v        = v;
		next_rpt      = repeat_instruction;
		next_left     = left;
		next_dest     = dest;
		next_mem_wr   = 1'b0;
		next_mem_addr = MEM_ADDR_OUT;
		next_mem_data = MEM_DATA_OUT;
		next_rdata    = `WORD_ZERO;
		if (REG_RD_IN) begin
			unique case (REG_ADDR_IN)
				`REG_ACC:    next_rdata = acc;
				`REG_PROD:   next_rdata = prod;
				`REG_FLAGS:  next_rdata = {28'h0000000, v, c, z, n};
				`REG_REPEAT: next_rdata = 32'(repeat_instruction);
				`REG_STATUS: next_rdata = {31'h00000000, !CMD_READY_OUT};
				default:     next_rdata = `WORD_ZERO;
			endcase
		end
		// Software writes land only while idle so they never race a running instruction.
		if (REG_WR_IN && CMD_READY_OUT && !CMD_VALID_IN) begin
			unique case (REG_ADDR_IN)
				`REG_ACC:    next_acc = REG_WDATA_IN;
				`REG_PROD:   next_prod = REG_WDATA_IN;
				`REG_FLAGS: begin
					next_n = REG_WDATA_IN[`FLG_N];
					next_z = REG_WDATA_IN[`FLG_Z];
					next_c = REG_WDATA_IN[`FLG_C];
					next_v = REG_WDATA_IN[`FLG_V];
				end
				`REG_REPEAT: next_rpt = REG_WDATA_IN[RPT_W-1:0];
				default: ;
			endcase
		end
		unique case (state)
			st_idle: begin
				if (CMD_VALID_IN) begin
					next_op   = CMD_OP_IN;
					next_high = CMD_HIGH_HALF_IN;
					next_dest = CMD_DEST_IN;
					next_left = repeat_instruction;
					next_state = st_exec;
					if (CMD_OP_IN == op_conditional_unsigned_product_minimum) begin
						next_left = '0;
						next_rpt  = '0;
					end else if (CMD_OP_IN == op_movabs) begin
						next_state = st_setup;
					end
				end
			end
			st_setup: next_state = st_exec;
			st_exec: begin
				unique case (op)
					op_min16: begin
						next_n = h_lt;
						next_z = h_eq;
						next_v = v | h_gt;
						if (h_gt) begin
							if (high) next_acc[31:16] = OPND_IN[15:0];
							else next_acc[15:0] = OPND_IN[15:0];
						end
					end
					op_long_accumulator_minimum: begin
						next_z = l_eq;
						next_n = l_lt;
						next_c = !l_borrow;
						next_v = v | l_gt | l_ovf;
						if (l_gt) next_acc = OPND_IN;
					end
					op_conditional_unsigned_product_minimum: begin
						if (!n && !z) begin
							next_prod = OPND_IN;
						end else if (!n && z && p_gt) begin
							next_prod = OPND_IN;
							next_v    = 1'b1;
						end
					end
					op_movabs: begin
						next_mem_wr   = 1'b1;
						next_mem_addr = {`HALF_ZERO, dest} & `ADDR_LOW_MASK;
						next_mem_data = OPND_IN[15:0];
						next_dest     = dest + `ADDR_STEP;
					end
				endcase
				if (left == '0) begin
					next_state = st_idle;
					next_rpt   = '0;
				end else begin
					next_left = left - 1'b1;
				end
			end
			default: next_state = st_idle;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			state         <= st_idle;
			op            <= op_min16;
			high          <= 1'b0;
			acc           <= `WORD_ZERO;
			prod          <= `WORD_ZERO;
			n             <= 1'b0;
			z             <= 1'b0;
			c             <= 1'b0;
			v             <= 1'b0;
			repeat_instruction           <= '0;
			left          <= '0;
			dest          <= `HALF_ZERO;
			MEM_WR_OUT    <= 1'b0;
			MEM_ADDR_OUT  <= `WORD_ZERO;
			MEM_DATA_OUT  <= `HALF_ZERO;
			REG_RDATA_OUT <= `WORD_ZERO;
		end else begin
			state         <= next_state;
			op            <= next_op;
			high          <= next_high;
			acc           <= next_acc;
			prod          <= next_prod;
			n             <= next_n;
			z             <= next_z;
			c             <= next_c;
			v             <= next_v;
			repeat_instruction           <= next_rpt;
			left          <= next_left;
			dest          <= next_dest;
			MEM_WR_OUT    <= next_mem_wr;
			MEM_ADDR_OUT  <= next_mem_addr;
			MEM_DATA_OUT  <= next_mem_data;
			REG_RDATA_OUT <= next_rdata;
		end
	end

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	logic ex16;
	logic exl;
	logic excul;
	logic acc_ok;
	assign ex16   = exe && op == op_min16;
	assign exl    = exe && op == op_long_accumulator_minimum;
	assign excul  = exe && op == op_conditional_unsigned_product_minimum;
	assign acc_ok = CMD_READY_OUT && CMD_VALID_IN;

	a_min16_replace: assert property (ex16 && h_gt |=> half == $past(OPND_IN[15:0]))
		else $error("Half not replaced by smaller operand.");
	a_min16_keep: assert property (ex16 && !h_gt |=> acc == $past(acc))
		else $error("Accumulator changed without greater half.");
	a_min16_neg: assert property (ex16 |=> n == $past(h_lt))
		else $error("Negative flag wrong after 16-bit minimum.");
	a_min16_zero: assert property (ex16 |=> z == $past(h_eq))
		else $error("Zero flag wrong after 16-bit minimum.");
	a_min16_ovf: assert property (ex16 |=> v == ($past(v) | $past(h_gt)))
		else $error("Overflow flag wrong after 16-bit minimum.");
	a_repeat_length: assert property (acc_ok && CMD_OP_IN == op_min16 && repeat_instruction == RPT_W'(2)
		|=> exe [*3] ##1 (!exe && repeat_instruction == '0))
		else $error("Repeated minimum did not run three cycles.");
	a_conditional_unsigned_product_minimum_once: assert property (acc_ok && CMD_OP_IN == op_conditional_unsigned_product_minimum
		|=> exe ##1 (!exe && repeat_instruction == '0))
		else $error("Product minimum not single cycle.");
	a_conditional_unsigned_product_minimum_load: assert property (excul && !n && (!z || p_gt) |=> prod == $past(OPND_IN))
		else $error("Product not loaded.");
	a_conditional_unsigned_product_minimum_hold: assert property (excul && (n || (z && !p_gt)) |=> prod == $past(prod))
		else $error("Product changed when it should hold.");
	a_conditional_unsigned_product_minimum_ovf: assert property (excul && !n && z && p_gt |=> v)
		else $error("Overflow not set by product minimum.");
	a_long_accumulator_minimum_acc: assert property (exl |=> acc == ($past(l_gt) ? $past(OPND_IN) : $past(acc)))
		else $error("Accumulator wrong after 32-bit minimum.");
	a_long_accumulator_minimum_zn: assert property (exl |=> z == $past(l_eq) && n == $past(l_lt))
		else $error("Zero or negative wrong after 32-bit minimum.");
	a_long_accumulator_minimum_carry: assert property (exl |=> c == !$past(l_borrow))
		else $error("Carry wrong after 32-bit minimum.");
	a_long_accumulator_minimum_ovf: assert property (exl |=> v == ($past(v) | $past(l_gt) | $past(l_ovf)))
		else $error("Overflow wrong after 32-bit minimum.");
	a_move_length: assert property (acc_ok && CMD_OP_IN == op_movabs && repeat_instruction == RPT_W'(2)
		|=> !exe ##1 exe [*3] ##1 !exe)
		else $error("Move did not take N+2 cycles.");
	a_move_low: assert property (MEM_WR_OUT |-> (MEM_ADDR_OUT & ~`ADDR_LOW_MASK) == `WORD_ZERO)
		else $error("Move address outside low 64K.");
	a_move_step: assert property (MEM_WR_OUT && $past(MEM_WR_OUT)
		|-> MEM_ADDR_OUT[15:0] == 16'($past(MEM_ADDR_OUT[15:0]) + `ADDR_STEP))
		else $error("Move address did not step by one.");
endmodule

// ===== minmove_params.svh
/*
 Constants for the minimum compare and move datapath: register offsets, flag
 bit positions, reset values and the address confinement of the absolute move.
 Assumes it is included by bare name after the package has been compiled.

// Summary of operation
// - 16-bit minimum: selected half takes the signed operand only when the half is greater.
// - 16-bit minimum: negative flag set when the half is less than the operand.
// - 16-bit minimum: zero flag set when the half equals the operand.
// - 16-bit minimum: overflow set when the half is greater, never cleared here.
// - Repeated 16-bit minimum runs N+1 times in N+1 cycles, flags show final result.
// - Conditional unsigned product minimum takes one cycle and does not repeat.
// - After a repeat, the product minimum clears the repeat counter and runs once.
// - Product minimum: N0 Z0 loads; N0 Z1 and product greater loads, sets overflow; N1 keeps.
// - Product minimum compares product and operand as unsigned 32-bit values.
// - 32-bit minimum loads the accumulator from the operand only when the accumulator is greater.
// - 32-bit minimum: zero flag set when accumulator equals the operand.
// - 32-bit minimum: negative flag from an exact signed compare, no wraparound.
// - 32-bit minimum: carry cleared on borrow of accumulator minus operand, else set.
// - 32-bit minimum repeats N+1 times; overflow also set by intermediate overflow, never cleared.
// - Absolute move copies a 16-bit operand to an immediate address in N+2 cycles.
// - Absolute move destination stays in the lowest 64K words, upper bits zero.
// - Repeated absolute move post-increments only the low 16 bits of the destination.
*/
`ifndef MINMOVE_PARAMS_SVH
`define MINMOVE_PARAMS_SVH
`define REG_ACC       8'h00
`define REG_PROD      8'h04
`define REG_FLAGS     8'h08
`define REG_REPEAT    8'h0C
`define REG_STATUS    8'h10
`define FLG_N         0
`define FLG_Z         1
`define FLG_C         2
`define FLG_V         3
`define WORD_ZERO     32'h00000000
`define HALF_ZERO     16'h0000
`define ADDR_LOW_MASK 32'h0000FFFF
`define ADDR_STEP     16'h0001
`endif

// ===== minmove_pkg.sv
/*
 Types shared by the minimum compare and move datapath.
 Assumes nothing of its surroundings.
*/
package minmove_pkg;
	typedef enum logic [1:0] {
		op_min16,
		op_long_accumulator_minimum,
		op_conditional_unsigned_product_minimum,
		op_movabs
	} opcode_e;
	typedef enum logic [1:0] {
		st_idle,
		st_setup,
		st_exec
	} state_e;
endpackage

// ===== tb_top.sv
/*
 Self-checking bench for the minimum compare and move unit.
 Assumes the package and the constants header are compiled before it.
*/
`timescale 1ns/1ns
`include "minmove_params.svh"
module tb_top;
	import minmove_pkg::*;
	logic        clk, rst, wr, rd, valid, hi, rd_q, n, z, c, v;
	logic [7:0]  addr;
	logic [15:0] dest;
	logic [31:0] wdata, opnd, acc, prod, rnd;
	opcode_e     op;
	wire  [31:0] rdata, maddr;
	wire  [15:0] mdata;
	wire         ready, take, mwr;
	int          error_cnt, checked, cycles, busy, oi, k;
	integer      seed = 32'h42E1;
	logic [31:0] ops[$], rq[$];
	logic [47:0] mq[$];
	int          tq[$];

	minimum_compare_move_unit i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CMD_VALID_IN(valid), .CMD_OP_IN(op),
		.CMD_HIGH_HALF_IN(hi), .CMD_DEST_IN(dest), .CMD_READY_OUT(ready), .OPND_IN(opnd),
		.OPND_TAKE_OUT(take), .MEM_WR_OUT(mwr), .MEM_ADDR_OUT(maddr), .MEM_DATA_OUT(mdata));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		rq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask

	task automatic read_all();
		reg_rd(`REG_ACC, acc);
		reg_rd(`REG_PROD, prod);
		reg_rd(`REG_FLAGS, {28'h0, v, c, z, n});
		reg_rd(`REG_REPEAT, 32'h0);
	endtask

	// The model walks the same operand list the unit consumes, so repeats check the final registers and every move write.
	task automatic cmd(input opcode_e o, input logic h, input logic [15:0] d, input int nrep, input logic [31:0] first);
		int          i;
		logic [32:0] df;
		logic [15:0] hv;
		reg_wr(`REG_REPEAT, 32'(nrep));
		ops.delete();
		oi = 0;
		ops.push_back(first);
		for (i = 0; i < nrep; i++) ops.push_back($random(seed));
		for (i = 0; i <= nrep; i++) begin
			hv = h ? acc[31:16] : acc[15:0];
			df = {acc[31], acc} - {ops[i][31], ops[i]};
			if (o == op_min16) begin
				n = $signed(hv) < $signed(ops[i][15:0]);
				z = hv == ops[i][15:0];
				if (!n && !z) {v, hv} = {1'b1, ops[i][15:0]};
				if (h) acc[31:16] = hv;
				else acc[15:0] = hv;
			end else if (o == op_long_accumulator_minimum) begin
				n = df[32];
				z = acc == ops[i];
				c = acc >= ops[i];
				v = v | (df[32] != df[31]) | (!n && !z);
				if (!n && !z) acc = ops[i];
			end else if (o == op_movabs) begin
				mq.push_back({16'h0, d + 16'(i), ops[i][15:0]});
			end
		end
		if (o == op_conditional_unsigned_product_minimum && !n && !z) prod = ops[0];
		else if (o == op_conditional_unsigned_product_minimum && !n && z && prod > ops[0]) {v, prod} = {1'b1, ops[0]};
		tq.push_back(o == op_conditional_unsigned_product_minimum ? 1 : (o == op_movabs ? nrep + 2 : nrep + 1));
		@(posedge clk);
		valid <= 1'b1;
		op    <= o;
		hi    <= h;
		dest  <= d;
		@(posedge clk);
		valid <= 1'b0;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (ready !== 1'b1 && i < 100);
		check("command done", 48'(ready), 48'(1));
		read_all();
	endtask

	always @(posedge clk) begin
		if (ready !== 1'b1) busy++;
		else if (busy != 0) begin
			check("busy cycles", 48'(busy), 48'(tq.size() ? tq.pop_front() : -1));
			busy = 0;
		end
		if (rd_q) check("read data", {16'h0, rdata}, {16'h0, rq.pop_front()});
		if (mwr === 1'b1) check("memory write", {maddr, mdata}, mq.size() ? mq.pop_front() : '1);
		rd_q <= rd;
		if (take === 1'b1) oi = oi + 1;
		opnd <= (oi < ops.size()) ? ops[oi] : ~opnd;
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	initial begin
		rst = 1'b1;
		{wr, rd, valid, hi, n, z, c, v} = '0;
		{addr, dest, wdata, opnd, acc, prod} = '0;
		op = op_min16;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		reg_rd(`REG_STATUS, 32'h0);
		reg_rd(8'h20, 32'h0);
		reg_wr(`REG_STATUS, 32'hFFFFFFFF);
		read_all();
		acc = 32'h80000000;
		reg_wr(`REG_ACC, acc);
		cmd(op_long_accumulator_minimum, 1'b0, 16'h0, 0, 32'h00000001);
		acc = 32'h00051234;
		reg_wr(`REG_ACC, acc);
		cmd(op_min16, 1'b0, 16'h0, 0, 32'h00001234);
		{v, c, z, n} = 4'h0;
		reg_wr(`REG_FLAGS, 32'h00000000);
		acc = 32'h7FFF0005;
		reg_wr(`REG_ACC, acc);
		cmd(op_min16, 1'b1, 16'h0, 2, 32'h00008000);
		for (k = 0; k < 3; k++) begin
			prod = 32'h80000000;
			reg_wr(`REG_PROD, prod);
			{v, c, z, n} = 4'(k == 0 ? 0 : (k == 1 ? 2 : 1));
			reg_wr(`REG_FLAGS, {28'h0, v, c, z, n});
			cmd(op_conditional_unsigned_product_minimum, 1'b0, 16'h0, 2, 32'h7FFFFFFF);
		end
		cmd(op_movabs, 1'b0, 16'hFFFE, 2, $random(seed));
		for (k = 0; k < 16; k++) begin
			rnd = $random(seed);
			cmd(opcode_e'(rnd[1:0]), rnd[2], rnd[31:16], int'(rnd[4:3]), $random(seed));
		end
		complete_run();
	end
endmodule
